// ### include/ses_cfg.svh
`ifndef SES_CFG_SVH
`define SES_CFG_SVH

// clock and timing
`define SES_CLK_NS 40
`define SES_PULSE_NS 700
`define SES_LOCK_NS 5700
`define SES_PULSE_CYC ((`SES_PULSE_NS + `SES_CLK_NS - 1) / `SES_CLK_NS)
`define SES_LOCK_CYC ((`SES_LOCK_NS + `SES_CLK_NS - 1) / `SES_CLK_NS)
`define SES_TMR_W 8

// event memory geometry
`define SES_ADDR_W 7
`define SES_WORD_W 16
`define SES_DEPTH 128

// event word fields
`define SES_POS_W 10
`define SES_POS_MAX 999
`define SES_MKR_BIT 10
`define SES_BX_BIT 11

`endif

// ### include/ses_pkg.sv
package ses_pkg;
`include "ses_cfg.svh"

    typedef enum logic [1:0] {
        SES_IDLE,
        SES_PULSE,
        SES_LOCK
    } ses_phase_t;

    // one cycle strobes from the host i/o decoder
    typedef struct packed {
        logic rd_strobe;
        logic wr_strobe;
        logic preset_strobe;
        logic [`SES_WORD_W-1:0] data;
    } ses_host_t;

    typedef struct packed {
        logic oe;
        logic [`SES_WORD_W-1:0] data;
    } ses_bus_out_t;

    typedef struct packed {
        ses_phase_t phase;
        logic [`SES_TMR_W-1:0] tmr;
        logic [`SES_ADDR_W-1:0] addr;
        logic pulse;
        logic marker;
        logic bandcross_n;
        logic rd_oe;
        logic cmp_s1;
        logic cmp_s2;
    } ses_state_t;

endpackage

// ### hw/ses_event_mem.sv
`timescale 1ns/10ps
module ses_event_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 128,
    parameter int AW = 7
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // access
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    // read word always follows the address, so the threshold tracks the counter
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else begin
            rdata <= mem[addr];
        end
    end
endmodule // ses_event_mem

// ### hw/ses_sweep_event_seq.sv
`timescale 1ns/10ps
`include "ses_cfg.svh"
// Operation
// - event write stores word then increments address
// - position is 0..999 on bits 9..0
// - address zero presents first stored position
// - match captures bits 10 and 11
// - marker uses two events: on, then off
// - preset strobe loads counter from bus
// - detect pulse advances the counter once
// - 128 by 16 memory, host read/write
// - one memory word per sweep event
// - bandcross events halt the sweep via the stop line
// - counter locates sweep position for slow sweeps
// - marker on/off spaced one thousandth apart
// - read strobe returns current word on bus
// - captured bit 10 drives the marker line
// - marker never stops; bandcross drives stop low
// - 700 ns pulse, 5.7 us lockout ignores matches
module ses_sweep_event_seq (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // host i/o strobes and data
    input ses_pkg::ses_host_t host_io,
    output ses_pkg::ses_bus_out_t host_bus,
    // sweep side
    input wire logic sweep_ramp_level,
    input wire logic sweep_stopped,
    input wire logic timer_disable,
    input wire logic clear_bandcross,
    // event outputs
    output logic [`SES_POS_W-1:0] event_position_bits,
    output logic [`SES_ADDR_W-1:0] event_address_lines,
    output logic marker_line,
    output logic bandcross_stop_n,
    output logic event_detect
);
    import ses_pkg::*;

    localparam logic [`SES_TMR_W-1:0] PULSE_LAST = `SES_TMR_W'(`SES_PULSE_CYC - 1);
    localparam logic [`SES_TMR_W-1:0] LOCK_LAST = `SES_TMR_W'(`SES_LOCK_CYC - 1);

    ses_state_t st;
    ses_state_t next_st;
    logic [`SES_WORD_W-1:0] mem_word;
    logic fire;
    logic adv;
    logic host_wr;

    function automatic logic [`SES_ADDR_W-1:0] inc_addr(input logic [`SES_ADDR_W-1:0] a,
                                                       input logic w,
                                                       input logic e);
        inc_addr = a + `SES_ADDR_W'(w) + `SES_ADDR_W'(e);
    endfunction

    // writes land at the current address, before it moves
    assign host_wr = host_io.wr_strobe && !host_io.preset_strobe;

    ses_event_mem #(
        .WIDTH(`SES_WORD_W),
        .DEPTH(`SES_DEPTH),
        .AW(`SES_ADDR_W)
    ) u_mem (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .we(host_wr),
        .addr(st.addr),
        .wdata(host_io.data),
        .rdata(mem_word)
    );

    // a stopped sweep or self-test blocks new matches; a pulse or lockout already running still completes
    assign fire = (st.phase == SES_IDLE) && st.cmp_s2 && !sweep_stopped && !timer_disable;
    assign adv = (st.phase == SES_PULSE) && (st.tmr == PULSE_LAST);

    always_comb begin
        next_st = st;
        next_st.cmp_s1 = sweep_ramp_level;
        next_st.cmp_s2 = st.cmp_s1;
        next_st.rd_oe = host_io.rd_strobe;
        if (host_io.preset_strobe) begin
            next_st.addr = host_io.data[`SES_ADDR_W-1:0];
        end else begin
            next_st.addr = inc_addr(st.addr, host_io.wr_strobe, adv);
        end
        unique case (st.phase)
            SES_IDLE: begin
                if (fire) begin
                    next_st.phase = SES_PULSE;
                    next_st.tmr = '0;
                    next_st.pulse = 1'b1;
                end
            end
            SES_PULSE: begin
                next_st.tmr = st.tmr + 1'b1;
                if (adv) begin
                    next_st.phase = SES_LOCK;
                    next_st.pulse = 1'b0;
                end
            end
            SES_LOCK: begin
                next_st.tmr = st.tmr + 1'b1;
                if (st.tmr == LOCK_LAST) begin
                    next_st.phase = SES_IDLE;
                end
            end
        endcase
        // event type flops clock on the match; a new set beats a host clear
        if (fire) begin
            next_st.marker = mem_word[`SES_MKR_BIT];
            // flop holds the stop level itself so the pin comes straight off it
            next_st.bandcross_n = !mem_word[`SES_BX_BIT];
        end else if (clear_bandcross) begin
            next_st.bandcross_n = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{phase: SES_IDLE, bandcross_n: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // threshold comes straight from the word at the current address
    // one position step is one thousandth of the span, the finest marker width
    assign event_position_bits = mem_word[`SES_POS_W-1:0];
    // host may read the address to find where a slow sweep stands
    assign event_address_lines = st.addr;
    assign marker_line = st.marker;
    assign bandcross_stop_n = st.bandcross_n;
    assign event_detect = st.pulse;
    assign host_bus.oe = st.rd_oe;
    assign host_bus.data = mem_word;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_match;
        fire;
    endsequence

    sequence s_pulse_run;
        ##17 event_detect ##1 !event_detect;
    endsequence

    a_preset_load:
    assert property (host_io.preset_strobe |=> st.addr == $past(host_io.data[6:0]))
        else $error("preset did not load address");

    a_write_advance:
    assert property (host_io.wr_strobe && !host_io.preset_strobe && !adv
                     |=> st.addr == $past(st.addr) + 7'h01)
        else $error("write did not advance address");

    a_pulse_width:
    assert property ($rose(event_detect) |-> s_pulse_run)
        else $error("detect pulse length wrong");

    a_lockout_span:
    assert property (s_match |=> ##142 (st.phase == SES_LOCK) ##1 (st.phase == SES_IDLE))
        else $error("lockout length wrong");

    a_no_refire:
    assert property (event_detect |-> !fire)
        else $error("match accepted during lockout");

    a_marker_capture:
    assert property (s_match |=> marker_line == $past(mem_word[10]))
        else $error("marker not taken from bit 10");

    a_bandcross_stop:
    assert property (s_match ##0 mem_word[11] |=> !bandcross_stop_n [*2])
        else $error("bandcross did not stop sweep");

    a_marker_no_stop:
    assert property (s_match ##0 !mem_word[11] |=> bandcross_stop_n)
        else $error("marker event stopped sweep");

    a_event_advance:
    assert property ($fell(event_detect) && !$past(host_io.preset_strobe)
                     && !$past(host_io.wr_strobe) |-> st.addr == $past(st.addr) + 7'h01)
        else $error("event did not advance address");

    a_read_drive:
    assert property (host_io.rd_strobe |=> host_bus.oe ##1 !host_bus.oe || $past(host_io.rd_strobe))
        else $error("read strobe did not drive bus");
endmodule // ses_sweep_event_seq

// ### verification/ses_host_model.sv
`timescale 1ns/10ps
module ses_host_model (
    // clock
    input wire logic core_clk,
    // host strobes and data
    output ses_pkg::ses_host_t host_io
);
    import ses_pkg::*;
    initial host_io = '0;
    // s is {rd, wr, preset}; released data lines show the inverse
    task automatic strobe(input logic [2:0] s, input logic [15:0] d);
        @(posedge core_clk);
        host_io <= {s, d};
        @(posedge core_clk);
        host_io <= {3'b000, ~d};
        @(negedge core_clk);
    endtask
endmodule // ses_host_model

// ### verification/tb_top.sv
`timescale 1ns/10ps
`include "ses_cfg.svh"
module tb_top;
    import ses_pkg::*;
    logic core_clk = 0;
    logic rst_n = 0;
    logic run = 0;
    logic clear_bandcross = 0;
    logic [9:0] ramp = 0;
    logic [9:0] pos;
    logic [6:0] addr;
    logic marker_line;
    logic bandcross_stop_n;
    logic event_detect;
    ses_host_t host_io;
    ses_bus_out_t host_bus;
    int n_mismatch = 0;
    int check_count = 0;
    // marker off sits one position step after marker on
    logic [15:0] w [4] = '{16'hf464, 16'h0065, 16'h09f4, 16'h0be7};
    initial forever #20 core_clk = ~core_clk;
    always @(posedge core_clk) if (run) ramp <= ramp + 10'h001;
    ses_host_model host (.core_clk(core_clk), .host_io(host_io));
    // comparator held low past the last written word, so an unwritten word never fires
    ses_sweep_event_seq dut (.core_clk(core_clk), .rst_n(rst_n), .host_io(host_io),
        .host_bus(host_bus), .sweep_ramp_level(run && addr < 7'h4 && ramp >= pos),
        .sweep_stopped(1'b0),
        .timer_disable(1'b0), .clear_bandcross(clear_bandcross),
        .event_position_bits(pos), .event_address_lines(addr), .marker_line(marker_line),
        .bandcross_stop_n(bandcross_stop_n), .event_detect(event_detect));
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic t_load;
        host.strobe(3'b001, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            host.strobe(3'b010, w[i]);
            chk("addr", 16'(addr), 16'(i + 1));
        end
        host.strobe(3'b001, 16'h0002);
        chk("preset", 16'(addr), 16'h0002);
        @(negedge core_clk);
        chk("pos", 16'(pos), 16'h01f4);
        host.strobe(3'b100, 16'h0000);
        chk("oe", 16'(host_bus.oe), 16'h0001);
        chk("rd", host_bus.data, w[2]);
        host.strobe(3'b001, 16'h0000);
        @(negedge core_clk);
        chk("pos0", 16'(pos), 16'h0064);
        $display("test load done");
    endtask
    task automatic t_event(input int i, input logic mk, input logic sn);
        int n;
        n = 0;
        while (event_detect !== 1'b1 && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        // next marker word sits one step on, so it waits out the lockout
        if (i == 1) chk("gap", 16'(n), 16'(`SES_LOCK_CYC - `SES_PULSE_CYC + 1));
        chk("mkr", 16'(marker_line), 16'(mk));
        chk("bx", 16'(bandcross_stop_n), 16'(sn));
        chk("adr", 16'(addr), 16'(i));
        n = 0;
        while (event_detect === 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        chk("pulse", 16'(n), 16'h0012);
        chk("adv", 16'(addr), 16'(i + 1));
        $display("test event %0d done", i);
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1;
        t_load;
        @(posedge core_clk);
        run <= 1;
        t_event(0, 1, 1);
        t_event(1, 0, 1);
        t_event(2, 0, 0);
        @(posedge core_clk);
        clear_bandcross <= 1;
        @(posedge core_clk);
        clear_bandcross <= 0;
        @(negedge core_clk);
        chk("clr", 16'(bandcross_stop_n), 16'h0001);
        t_event(3, 0, 0);
        complete_run;
    end
    initial begin
        #200000;
        n_mismatch++;
        complete_run;
    end
endmodule // tb_top
